// ==== bmseq_pkg.sv ====
// Package of constants and types for the boot mode sequencer.
package bmseq_pkg;
   // Flash word addresses, byte offsets as stored.
   localparam logic [17:0] USER_FLASH_SIZE  = 18'h20000;
   localparam logic [17:0] PAGE0_VALID_ADDR = 18'h007fc;
   localparam logic [17:0] PAGE0_BASE       = 18'h00000;
   localparam logic [17:0] PAGE_BYTES       = 18'h00800;
   localparam logic [17:0] BL_CRC_OFS       = 18'h00004;
   localparam logic [17:0] BL_LOW_OFS       = 18'h0001c;
   localparam logic [17:0] BL_ENTRY_OFS     = 18'h00020;
   localparam logic [17:0] BL_MAX_BYTES     = 18'h07800;
   localparam logic [17:0] DEBUG_LOCK_ADDR  = 18'h1fffc;
   localparam logic [17:0] KERNEL_BASE      = 18'h20000;
   localparam logic [17:0] KERNEL_BYTES     = 18'h00800;
   localparam logic [17:0] WORD_STEP        = 18'h00004;
   // Keys and fixed targets.
   localparam logic [31:0] DEBUG_LOCK_KEY   = 32'h00160320;
   localparam logic [31:0] PAGE0_KEY        = 32'h16400000;
   localparam logic [31:0] DEBUG_ENTRY      = 32'h00000000;
   localparam logic [31:0] CRC_POLY         = 32'h04c11db7;
   localparam logic [31:0] CRC_INIT         = 32'hffffffff;
   // Calibration table geometry.
   localparam logic [3:0]  CAL_COUNT        = 4'h8;
   localparam logic [17:0] CAL_BASE         = 18'h20700;
   localparam logic [17:0] CAL_SUM_ADDR     = 18'h207f8;
   localparam logic [17:0] KERNEL_SIG_ADDR  = 18'h207fc;
   // Download timeout: one hour at 125 MHz.
   localparam longint     TIMEOUT_SEC      = 3600;
   localparam longint     CLK_HZ           = 125000000;
   localparam logic [39:0] TIMEOUT_CYC     = 40'(TIMEOUT_SEC * CLK_HZ);
   // Fast download bit rate ceiling.
   localparam longint     FAST_BAUD        = 100000;
   localparam logic [15:0] FAST_BIT_CYC    = 16'(CLK_HZ / FAST_BAUD);
   // Sequencer states.
   typedef enum logic [4:0] {
      BMSEQ_KCRC, BMSEQ_KSIG, BMSEQ_BLOCKED, BMSEQ_CAL_RD, BMSEQ_CAL_WR,
      BMSEQ_CHK_RD, BMSEQ_CHK_CMP, BMSEQ_SRAM, BMSEQ_STRAP, BMSEQ_P0_VW,
      BMSEQ_P0_CRC, BMSEQ_BL_ENT, BMSEQ_BL_LOW, BMSEQ_BL_SIG, BMSEQ_BL_CRC,
      BMSEQ_LOCK, BMSEQ_EXIT, BMSEQ_DOWNLOAD, BMSEQ_FAILSAFE, BMSEQ_RSTREQ
   } bmseq_state_t;
   typedef enum logic [1:0] {
      BMSEQ_MODE_DEBUG, BMSEQ_MODE_USER, BMSEQ_MODE_BOOT, BMSEQ_MODE_LOAD
   } bmseq_mode_t;
endpackage

// ==== bmseq_crc.sv ====
`timescale 1ns/100ps
// Word-wide CRC accumulator used for every signature in the sequencer.
module bmseq_crc (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Control.
   input  wire logic        clear,
   input  wire logic        feed,
   input  wire logic [31:0] data,
   // Result.
   output logic      [31:0] crc
);
   // One MSB-first step over a whole word; shared so all signatures match.
   function automatic logic [31:0] crc_word(input logic [31:0] c,
                                            input logic [31:0] d);
      logic [31:0] r;
      r = c ^ d;
      for (int i = 0; i < 32; i++) begin
         r = r[31] ? ((r << 1) ^ bmseq_pkg::CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   // Accumulate on feed, restart on clear.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crc <= bmseq_pkg::CRC_INIT;
      end else if (clear) begin
         crc <= bmseq_pkg::CRC_INIT;
      end else if (feed) begin
         crc <= crc_word(crc, data);
      end
   end
endmodule

// ==== bmseq_top.sv ====
`timescale 1ns/100ps
// Boot mode sequencer: integrity checks, calibration load, mode choice.
module bmseq_top (
   // Clock and reset.
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   input  wire logic        POR_N,
   // Flash read port, one word per request, held until FLASH_VALID unless a page 0 CRC match or the fail-safe flag ends the read first.
   output logic             FLASH_RD,
   output logic      [17:0] FLASH_ADDR,
   input  wire logic [31:0] FLASH_RDATA,
   input  wire logic        FLASH_VALID,
   // Calibration register write and read-back port.
   output logic             CAL_WR,
   output logic      [2:0]  CAL_IDX,
   output logic      [31:0] CAL_WDATA,
   input  wire logic [31:0] CAL_RDATA,
   // Flash data high register load.
   output logic             FLASH_DATA_HIGH_WR,
   output logic      [31:0] FLASH_DATA_HIGH_REG,
   // SRAM check engine.
   output logic             SRAM_CHK_START,
   input  wire logic        SRAM_CHK_DONE,
   input  wire logic        SRAM_ECC_DOUBLE,
   output logic             SRAM_ZERO_FILL,
   output logic             SOFT_RESET_REQ,
   // Strap and LIN download link.
   input  wire logic        BOOT_MODE_STRAP_PIN,
   input  wire logic        LIN_FRAME_OK,
   input  wire logic        LIN_DONE,
   output logic             LIN_FAST_EN,
   output logic      [15:0] LIN_BIT_CYC,
   // Outcome.
   output logic             SWD_EN,
   output logic             KERNEL_BLOCKED,
   output logic             BRANCH_VALID,
   output logic      [31:0] BRANCH_ADDR,
   output logic      [1:0]  BOOT_MODE,
   output logic             FAILSAFE
);
   parameter logic [39:0] TIMEOUT = bmseq_pkg::TIMEOUT_CYC;

   bmseq_pkg::bmseq_state_t state_reg;
   logic [17:0] addr_reg;
   logic [3:0]  idx_reg;
   logic [31:0] sum_reg;
   logic [31:0] word_reg;
   logic [31:0] bl_entry_reg;
   logic [17:0] bl_low_reg;
   logic [39:0] idle_cnt_reg;
   logic        strap_s1_reg;
   logic        strap_s2_reg;
   logic        lock_reg;
   logic        failsafe_reg;
   logic        crc_clear;
   logic        crc_feed;
   logic [31:0] crc_val;
   logic [17:0] bl_span;

   bmseq_crc u_crc (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .clear (crc_clear),
      .feed  (crc_feed),
      .data  (FLASH_RDATA),
      .crc   (crc_val)
   );

   // Strap pin comes from outside; two flops before use.
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         strap_s1_reg <= 1'b0;
         strap_s2_reg <= 1'b0;
      end else begin
         strap_s1_reg <= BOOT_MODE_STRAP_PIN;
         strap_s2_reg <= strap_s1_reg;
      end
   end

   // Fail-safe survives ordinary resets; only power-on clears it.
   always_ff @(posedge REF_CLK or negedge POR_N) begin
      if (!POR_N) begin
         failsafe_reg <= 1'b0;
      end else if (state_reg == bmseq_pkg::BMSEQ_FAILSAFE) begin
         failsafe_reg <= 1'b1;
      end
   end

   assign bl_span = bmseq_pkg::USER_FLASH_SIZE - bl_low_reg;
   // The request stands through the edge that takes the word; it must not
   // depend on the memory's answer, or the two would form a loop.
   assign FLASH_RD = state_reg inside {
      bmseq_pkg::BMSEQ_KCRC, bmseq_pkg::BMSEQ_KSIG,
      bmseq_pkg::BMSEQ_CAL_RD, bmseq_pkg::BMSEQ_CHK_CMP,
      bmseq_pkg::BMSEQ_P0_VW,
      bmseq_pkg::BMSEQ_P0_CRC, bmseq_pkg::BMSEQ_BL_ENT,
      bmseq_pkg::BMSEQ_BL_LOW, bmseq_pkg::BMSEQ_BL_SIG,
      bmseq_pkg::BMSEQ_BL_CRC, bmseq_pkg::BMSEQ_LOCK};
   assign FLASH_ADDR = addr_reg;
   // The CRC engine only sees words from ranges being hashed.
   assign crc_feed = FLASH_VALID && (state_reg inside {
      bmseq_pkg::BMSEQ_KCRC, bmseq_pkg::BMSEQ_P0_CRC,
      bmseq_pkg::BMSEQ_BL_CRC});
   // Clear only as the signature word is taken, so a slow memory cannot
   // wipe the result before the compare has used it.
   assign crc_clear = FLASH_VALID && (state_reg inside {
      bmseq_pkg::BMSEQ_KSIG, bmseq_pkg::BMSEQ_P0_VW,
      bmseq_pkg::BMSEQ_BL_SIG});
   assign SWD_EN = (state_reg == bmseq_pkg::BMSEQ_EXIT) && !lock_reg;
   assign FAILSAFE = failsafe_reg;
   assign LIN_FAST_EN = (state_reg == bmseq_pkg::BMSEQ_DOWNLOAD);
   assign LIN_BIT_CYC = bmseq_pkg::FAST_BIT_CYC;

   // Main sequence; restarts only when RST_N asserts.
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_reg <= bmseq_pkg::BMSEQ_KCRC;
         addr_reg <= bmseq_pkg::KERNEL_BASE;
         idx_reg <= 4'h0;
         sum_reg <= 32'h00000000;
         word_reg <= 32'h00000000;
         bl_entry_reg <= 32'h00000000;
         bl_low_reg <= 18'h00000;
         lock_reg <= 1'b1;
         idle_cnt_reg <= 40'h0000000000;
         CAL_WR <= 1'b0;
         CAL_IDX <= 3'h0;
         CAL_WDATA <= 32'h00000000;
         FLASH_DATA_HIGH_WR <= 1'b0;
         FLASH_DATA_HIGH_REG <= 32'h00000000;
         SRAM_CHK_START <= 1'b0;
         SRAM_ZERO_FILL <= 1'b0;
         SOFT_RESET_REQ <= 1'b0;
         KERNEL_BLOCKED <= 1'b0;
         BRANCH_VALID <= 1'b0;
         BRANCH_ADDR <= 32'h00000000;
         BOOT_MODE <= bmseq_pkg::BMSEQ_MODE_DEBUG;
      end else begin
         CAL_WR <= 1'b0;
         FLASH_DATA_HIGH_WR <= 1'b0;
         SRAM_CHK_START <= 1'b0;
         unique case (state_reg)
            bmseq_pkg::BMSEQ_KCRC: if (failsafe_reg) begin
               state_reg <= bmseq_pkg::BMSEQ_FAILSAFE;
            end else if (FLASH_VALID) begin
               if (addr_reg == bmseq_pkg::KERNEL_SIG_ADDR
                               - bmseq_pkg::WORD_STEP) begin
                  addr_reg <= bmseq_pkg::KERNEL_SIG_ADDR;
                  state_reg <= bmseq_pkg::BMSEQ_KSIG;
               end else begin
                  addr_reg <= addr_reg + bmseq_pkg::WORD_STEP;
               end
            end
            bmseq_pkg::BMSEQ_KSIG: if (FLASH_VALID) begin
               if (FLASH_RDATA != crc_val) begin
                  KERNEL_BLOCKED <= 1'b1;
                  state_reg <= bmseq_pkg::BMSEQ_BLOCKED;
               end else begin
                  addr_reg <= bmseq_pkg::CAL_BASE;
                  state_reg <= bmseq_pkg::BMSEQ_CAL_RD;
               end
            end
            bmseq_pkg::BMSEQ_BLOCKED: state_reg <= bmseq_pkg::BMSEQ_BLOCKED;
            bmseq_pkg::BMSEQ_CAL_RD: if (FLASH_VALID) begin
               CAL_WR <= 1'b1;
               CAL_IDX <= idx_reg[2:0];
               CAL_WDATA <= FLASH_RDATA;
               state_reg <= bmseq_pkg::BMSEQ_CAL_WR;
            end
            bmseq_pkg::BMSEQ_CAL_WR: begin
               addr_reg <= addr_reg + bmseq_pkg::WORD_STEP;
               if (idx_reg == bmseq_pkg::CAL_COUNT - 4'h1) begin
                  idx_reg <= 4'h0;
                  CAL_IDX <= 3'h0;
                  state_reg <= bmseq_pkg::BMSEQ_CHK_RD;
               end else begin
                  idx_reg <= idx_reg + 4'h1;
                  state_reg <= bmseq_pkg::BMSEQ_CAL_RD;
               end
            end
            // Read back each trim and sum; index drives CAL_IDX.
            bmseq_pkg::BMSEQ_CHK_RD: begin
               sum_reg <= sum_reg + CAL_RDATA;
               if (idx_reg == bmseq_pkg::CAL_COUNT - 4'h1) begin
                  addr_reg <= bmseq_pkg::CAL_SUM_ADDR;
                  state_reg <= bmseq_pkg::BMSEQ_CHK_CMP;
               end else begin
                  idx_reg <= idx_reg + 4'h1;
                  CAL_IDX <= 3'(idx_reg + 4'h1);
               end
            end
            bmseq_pkg::BMSEQ_CHK_CMP: if (FLASH_VALID) begin
               if (FLASH_RDATA != sum_reg) begin
                  FLASH_DATA_HIGH_WR <= 1'b1;
                  FLASH_DATA_HIGH_REG <= sum_reg;
               end
               SRAM_CHK_START <= 1'b1;
               state_reg <= bmseq_pkg::BMSEQ_SRAM;
            end
            // Single errors are fixed inside the engine; double ones reset.
            bmseq_pkg::BMSEQ_SRAM: if (SRAM_ECC_DOUBLE) begin
               SRAM_ZERO_FILL <= 1'b1;
               state_reg <= bmseq_pkg::BMSEQ_RSTREQ;
            end else if (SRAM_CHK_DONE) begin
               state_reg <= bmseq_pkg::BMSEQ_STRAP;
            end
            bmseq_pkg::BMSEQ_RSTREQ: begin
               SRAM_ZERO_FILL <= 1'b0;
               SOFT_RESET_REQ <= 1'b1;
            end
            bmseq_pkg::BMSEQ_STRAP: if (!strap_s2_reg) begin
               BOOT_MODE <= bmseq_pkg::BMSEQ_MODE_DEBUG;
               BRANCH_ADDR <= bmseq_pkg::DEBUG_ENTRY;
               addr_reg <= bmseq_pkg::DEBUG_LOCK_ADDR;
               state_reg <= bmseq_pkg::BMSEQ_LOCK;
            end else begin
               addr_reg <= bmseq_pkg::PAGE0_VALID_ADDR;
               state_reg <= bmseq_pkg::BMSEQ_P0_VW;
            end
            bmseq_pkg::BMSEQ_P0_VW: if (FLASH_VALID) begin
               word_reg <= FLASH_RDATA;
               BOOT_MODE <= bmseq_pkg::BMSEQ_MODE_USER;
               BRANCH_ADDR <= {14'h0000, bmseq_pkg::PAGE0_BASE};
               if (FLASH_RDATA == bmseq_pkg::PAGE0_KEY) begin
                  addr_reg <= bmseq_pkg::DEBUG_LOCK_ADDR;
                  state_reg <= bmseq_pkg::BMSEQ_LOCK;
               end else begin
                  addr_reg <= bmseq_pkg::PAGE0_BASE;
                  state_reg <= bmseq_pkg::BMSEQ_P0_CRC;
               end
            end
            bmseq_pkg::BMSEQ_P0_CRC: if (FLASH_VALID) begin
               if (addr_reg == bmseq_pkg::PAGE0_VALID_ADDR
                               - bmseq_pkg::WORD_STEP) begin
                  state_reg <= bmseq_pkg::BMSEQ_BL_ENT;
                  addr_reg <= bmseq_pkg::USER_FLASH_SIZE
                              - bmseq_pkg::BL_ENTRY_OFS;
               end else begin
                  addr_reg <= addr_reg + bmseq_pkg::WORD_STEP;
               end
            end
            bmseq_pkg::BMSEQ_BL_ENT: if (word_reg == crc_val) begin
               addr_reg <= bmseq_pkg::DEBUG_LOCK_ADDR;
               state_reg <= bmseq_pkg::BMSEQ_LOCK;
            end else if (FLASH_VALID) begin
               bl_entry_reg <= FLASH_RDATA;
               addr_reg <= bmseq_pkg::USER_FLASH_SIZE - bmseq_pkg::BL_LOW_OFS;
               state_reg <= bmseq_pkg::BMSEQ_BL_LOW;
            end
            bmseq_pkg::BMSEQ_BL_LOW: if (FLASH_VALID) begin
               bl_low_reg <= FLASH_RDATA[17:0];
               state_reg <= bmseq_pkg::BMSEQ_BL_SIG;
               addr_reg <= bmseq_pkg::USER_FLASH_SIZE - bmseq_pkg::BL_CRC_OFS;
            end
            // Range checks: entry odd, not below the image and under 18 bits, image at most 30 kB.
            bmseq_pkg::BMSEQ_BL_SIG: if (FLASH_VALID) begin
               word_reg <= FLASH_RDATA;
               if (!bl_entry_reg[0]
                   || bl_entry_reg[31:18] != 14'h0000
                   || bl_low_reg >= bmseq_pkg::USER_FLASH_SIZE
                   || bl_span > bmseq_pkg::BL_MAX_BYTES
                   || bl_entry_reg[17:0] < bl_low_reg) begin
                  state_reg <= bmseq_pkg::BMSEQ_DOWNLOAD;
               end else begin
                  addr_reg <= bl_low_reg;
                  state_reg <= bmseq_pkg::BMSEQ_BL_CRC;
               end
            end
            bmseq_pkg::BMSEQ_BL_CRC: if (FLASH_VALID) begin
               if (addr_reg >= bmseq_pkg::USER_FLASH_SIZE
                               - bmseq_pkg::BL_ENTRY_OFS
                               - bmseq_pkg::WORD_STEP) begin
                  state_reg <= bmseq_pkg::BMSEQ_EXIT;
               end else begin
                  addr_reg <= addr_reg + bmseq_pkg::WORD_STEP;
               end
            end
            // Bootloader CRC verdict lands one cycle after the last word.
            bmseq_pkg::BMSEQ_EXIT: if (BOOT_MODE == bmseq_pkg::BMSEQ_MODE_USER
                                       && !BRANCH_VALID) begin
               if (word_reg == crc_val) begin
                  BOOT_MODE <= bmseq_pkg::BMSEQ_MODE_BOOT;
                  BRANCH_ADDR <= bl_entry_reg;
                  addr_reg <= bmseq_pkg::DEBUG_LOCK_ADDR;
                  state_reg <= bmseq_pkg::BMSEQ_LOCK;
               end else begin
                  state_reg <= bmseq_pkg::BMSEQ_DOWNLOAD;
               end
            end else begin
               BRANCH_VALID <= 1'b1;
            end
            bmseq_pkg::BMSEQ_LOCK: if (FLASH_VALID) begin
               lock_reg <= (FLASH_RDATA == bmseq_pkg::DEBUG_LOCK_KEY);
               BRANCH_VALID <= 1'b1;
               state_reg <= bmseq_pkg::BMSEQ_EXIT;
            end
            // Download holds until reset or the idle timeout sends it to fail-safe; done does not leave the state.
            bmseq_pkg::BMSEQ_DOWNLOAD: begin
               BOOT_MODE <= bmseq_pkg::BMSEQ_MODE_LOAD;
               if (LIN_FRAME_OK || LIN_DONE) begin
                  idle_cnt_reg <= 40'h0000000000;
               end else if (idle_cnt_reg >= TIMEOUT - 40'h1) begin
                  state_reg <= bmseq_pkg::BMSEQ_FAILSAFE;
               end else begin
                  idle_cnt_reg <= idle_cnt_reg + 40'h1;
               end
            end
            bmseq_pkg::BMSEQ_FAILSAFE: state_reg <= bmseq_pkg::BMSEQ_FAILSAFE;
            default: state_reg <= bmseq_pkg::BMSEQ_BLOCKED;
         endcase
      end
   end
endmodule

// ==== bmseq_top_sva.sv ====
`timescale 1ns/100ps
// Checker of the boot mode sequencer's outcome ports.
module bmseq_top_sva (
   // Clock and reset.
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   // Outcome.
   input wire logic        SWD_EN,
   input wire logic        KERNEL_BLOCKED,
   input wire logic        BRANCH_VALID,
   input wire logic [31:0] BRANCH_ADDR,
   input wire logic [1:0]  BOOT_MODE,
   input wire logic        FAILSAFE,
   // Side effects.
   input wire logic        FLASH_DATA_HIGH_WR,
   input wire logic        SRAM_ZERO_FILL,
   input wire logic        SOFT_RESET_REQ,
   input wire logic        LIN_FAST_EN,
   input wire logic [15:0] LIN_BIT_CYC
);
   // One clock domain, so one clocking and one disable serve all.
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // A finished branch in each exit mode.
   wire exit_debug = BRANCH_VALID && BOOT_MODE == bmseq_pkg::BMSEQ_MODE_DEBUG;
   wire exit_user  = BRANCH_VALID && BOOT_MODE == bmseq_pkg::BMSEQ_MODE_USER;
   wire exit_boot  = BRANCH_VALID && BOOT_MODE == bmseq_pkg::BMSEQ_MODE_BOOT;
   a_swd_only_exit: assert property (SWD_EN |-> BRANCH_VALID && !LIN_FAST_EN)
      else $error("debug port open before exit");
   a_block_no_exit: assert property (KERNEL_BLOCKED |-> !BRANCH_VALID && !SWD_EN)
      else $error("blocked kernel still exits");
   a_high_one_pulse: assert property (FLASH_DATA_HIGH_WR |=> !FLASH_DATA_HIGH_WR)
      else $error("data high write longer than one cycle");
   a_fill_then_reset: assert property (SRAM_ZERO_FILL |-> ##[0:4] SOFT_RESET_REQ)
      else $error("zero fill without soft reset request");
   a_reset_req_holds: assert property (SOFT_RESET_REQ |=> SOFT_RESET_REQ && !BRANCH_VALID)
      else $error("soft reset request dropped or branch taken");
   a_debug_at_zero: assert property (exit_debug |-> BRANCH_ADDR == bmseq_pkg::DEBUG_ENTRY)
      else $error("debug branch not at address zero");
   a_user_at_page: assert property (exit_user |-> BRANCH_ADDR == 32'h0)
      else $error("user branch not at first page");
   a_boot_odd_entry: assert property (exit_boot |-> BRANCH_ADDR[0])
      else $error("bootloader entry even");
   a_fast_bit_rate: assert property (LIN_FAST_EN |-> LIN_BIT_CYC == 16'h04e2)
      else $error("fast download bit time wrong");
   a_exit_is_final: assert property (BRANCH_VALID |=> BRANCH_VALID && $stable(BRANCH_ADDR))
      else $error("branch changed without reset");
   a_failsafe_kept: assert property (FAILSAFE |=> FAILSAFE)
      else $error("fail-safe left without power cycle");
   // Main outcomes worth seeing at least once.
   c_boot_exit: cover property (exit_boot);
   c_failsafe: cover property ($rose(FAILSAFE));
   c_blocked: cover property (KERNEL_BLOCKED);
endmodule
bind bmseq_top bmseq_top_sva CHK (.REF_CLK, .RST_N, .SWD_EN, .KERNEL_BLOCKED,
   .BRANCH_VALID, .BRANCH_ADDR, .BOOT_MODE, .FAILSAFE, .FLASH_DATA_HIGH_WR,
   .SRAM_ZERO_FILL, .SOFT_RESET_REQ, .LIN_FAST_EN, .LIN_BIT_CYC);

// ==== bmseq_flash_model.sv ====
`timescale 1ns/100ps
// Flash memory model that answers the sequencer's word reads.
module bmseq_flash_model (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Read port.
   input  wire logic        rd,
   input  wire logic [17:0] addr,
   input  wire logic        slow,
   output logic      [31:0] rdata,
   output logic             valid
);
   logic [31:0] mem [logic [17:0]];
   logic [1:0]  wait_reg;
   logic [31:0] last_reg;
   // Unwritten words read as erased flash, all ones.
   function automatic logic [31:0] peek(input logic [17:0] a);
      return mem.exists(a) ? mem[a] : 32'hffffffff;
   endfunction
   // Slow answers come two cycles late; idle data toggles every cycle.
   assign valid = rd && (!slow || wait_reg == 2'h2);
   assign rdata = valid ? peek(addr) : ~last_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_reg <= 2'h0;
         last_reg <= 32'h0;
      end else begin
         wait_reg <= (rd && !valid) ? wait_reg + 2'h1 : 2'h0;
         last_reg <= rdata;
      end
   end
endmodule

// ==== bmseq_top_test.sv ====
`timescale 1ns/100ps
// Self-checking bench for the boot mode sequencer.
module bmseq_top_test;
   // One boot per row: image choices beside the outcome they must give.
   typedef struct packed {
      logic        strap;
      logic [1:0]  p0;
      logic [1:0]  bl;
      logic        lock;
      logic        bad_sum;
      logic        slow;
      logic [1:0]  mode;
      logic [31:0] addr;
      logic        swd;
   } bmseq_row_t;
   bmseq_row_t  rows [8] = '{
      '{1'h0, 2'h0, 2'h0, 1'h0, 1'h0, 1'h0, 2'h0, 32'h0, 1'h1},
      '{1'h1, 2'h1, 2'h0, 1'h1, 1'h1, 1'h1, 2'h1, 32'h0, 1'h0},
      '{1'h1, 2'h2, 2'h0, 1'h0, 1'h0, 1'h0, 2'h1, 32'h0, 1'h1},
      '{1'h1, 2'h0, 2'h1, 1'h0, 1'h0, 1'h1, 2'h2, 32'h1ff01, 1'h1},
      '{1'h1, 2'h0, 2'h0, 1'h0, 1'h0, 1'h0, 2'h3, 32'h0, 1'h0},
      '{1'h1, 2'h0, 2'h2, 1'h0, 1'h0, 1'h1, 2'h3, 32'h0, 1'h0},
      '{1'h1, 2'h0, 2'h3, 1'h0, 1'h0, 1'h0, 2'h3, 32'h0, 1'h0},
      '{1'h0, 2'h1, 2'h0, 1'h1, 1'h0, 1'h1, 2'h0, 32'h0, 1'h0}};
   logic        REF_CLK, RST_N, POR_N, FLASH_RD, FLASH_VALID, CAL_WR;
   logic        FLASH_DATA_HIGH_WR, SRAM_CHK_START, SRAM_CHK_DONE;
   logic        SRAM_ECC_DOUBLE, SRAM_ZERO_FILL, SOFT_RESET_REQ, FAILSAFE;
   logic        BOOT_MODE_STRAP_PIN, LIN_FRAME_OK, LIN_DONE, LIN_FAST_EN;
   logic        SWD_EN, KERNEL_BLOCKED, BRANCH_VALID, slow;
   logic [1:0]  BOOT_MODE, sram_cnt;
   logic [2:0]  CAL_IDX;
   logic [15:0] LIN_BIT_CYC;
   logic [17:0] FLASH_ADDR;
   logic [31:0] FLASH_RDATA, CAL_WDATA, CAL_RDATA, FLASH_DATA_HIGH_REG;
   logic [31:0] BRANCH_ADDR, dh_val, sum_exp;
   logic [31:0] cal_reg [8];
   int          fail_count, n_tests, cyc, dh_count, zf_count, wr_count;
   // A short download timeout keeps the fail-safe case quick.
   bmseq_top #(.TIMEOUT(40'h32)) DUT (.REF_CLK, .RST_N, .POR_N, .FLASH_RD,
      .FLASH_ADDR, .FLASH_RDATA, .FLASH_VALID, .CAL_WR, .CAL_IDX, .CAL_WDATA,
      .CAL_RDATA, .FLASH_DATA_HIGH_WR, .FLASH_DATA_HIGH_REG, .SRAM_CHK_START,
      .SRAM_CHK_DONE, .SRAM_ECC_DOUBLE, .SRAM_ZERO_FILL, .SOFT_RESET_REQ,
      .BOOT_MODE_STRAP_PIN, .LIN_FRAME_OK, .LIN_DONE, .LIN_FAST_EN,
      .LIN_BIT_CYC, .SWD_EN, .KERNEL_BLOCKED, .BRANCH_VALID, .BRANCH_ADDR,
      .BOOT_MODE, .FAILSAFE);
   bmseq_flash_model FLASH (.clk(REF_CLK), .rst_n(RST_N), .rd(FLASH_RD),
      .addr(FLASH_ADDR), .slow(slow), .rdata(FLASH_RDATA), .valid(FLASH_VALID));
   // Free-running 125 MHz clock.
   initial begin
      REF_CLK = 1'b0;
      forever #4 REF_CLK = ~REF_CLK;
   end
   // Trims answer read-back at once; SRAM check and watchdog live here.
   assign CAL_RDATA = cal_reg[CAL_IDX];
   always @(posedge REF_CLK) begin
      cyc++;
      sram_cnt <= SRAM_CHK_START === 1'b1 ? 2'h3 : sram_cnt - 2'(sram_cnt != 0);
      SRAM_CHK_DONE <= sram_cnt == 2'h1;
      if (CAL_WR === 1'b1) begin
         cal_reg[CAL_IDX] <= CAL_WDATA;
         wr_count++;
      end
      if (FLASH_DATA_HIGH_WR === 1'b1) begin
         dh_count++;
         dh_val = FLASH_DATA_HIGH_REG;
      end
      if (SRAM_ZERO_FILL === 1'b1) begin
         zf_count++;
      end
      if (cyc == 60000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   function automatic logic [31:0] cal_word(input int i);
      return 32'h01030507 * 32'(i + 1);
   endfunction
   // MSB-first word CRC, the one algorithm for every signature.
   function automatic logic [31:0] crc_span(input logic [17:0] lo, hi);
      logic [31:0] c;
      logic [31:0] d;
      c = 32'hffffffff;
      for (int a = lo; a <= hi; a += 4) begin
         d = FLASH.peek(18'(a));
         for (int i = 31; i >= 0; i--) begin
            c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? 32'h04c11db7 : 32'h0);
         end
      end
      return c;
   endfunction
   // Builds the flash image; the first-page word is written last.
   task automatic load(input bmseq_row_t r, input logic bad_sig);
      logic [17:0] low;
      sum_exp = 32'h0;
      for (int i = 0; i < 8; i++) begin
         FLASH.mem[bmseq_pkg::CAL_BASE + 18'(4 * i)] = cal_word(i);
         sum_exp += cal_word(i);
      end
      FLASH.mem[18'h207f8] = sum_exp + 32'(r.bad_sum);
      FLASH.mem[18'h207fc] = crc_span(18'h20000, 18'h207f8) ^ 32'(bad_sig);
      low = r.bl == 2'h3 ? 18'h18000 : 18'h1ff00;
      FLASH.mem[low] = 32'h4a4b4c4d;
      FLASH.mem[18'h1ffe4] = r.bl == 2'h0 ? 32'h0 : 32'(low);
      FLASH.mem[18'h1ffe0] = r.bl == 2'h0 ? 32'h0fffffff
         : 32'(low) + 32'(r.bl != 2'h2);
      FLASH.mem[18'h1fffc] = r.bl != 2'h0 ? crc_span(low, 18'h1ffdc)
         : r.lock ? bmseq_pkg::DEBUG_LOCK_KEY : 32'h0;
      FLASH.mem[18'h0] = 32'h9abcdef1;
      FLASH.mem[18'h7fc] = r.p0 == 2'h2 ? bmseq_pkg::PAGE0_KEY
         : r.p0 == 2'h1 ? crc_span(18'h0, 18'h7f8) : 32'h0;
   endtask
   // Resets with a fresh image, then waits a bounded time for the outcome.
   task automatic boot(input bmseq_row_t r, input logic bad_sig, ecc, por);
      @(posedge REF_CLK);
      RST_N <= 1'b0;
      POR_N <= !por;
      slow <= r.slow;
      BOOT_MODE_STRAP_PIN <= r.strap;
      SRAM_ECC_DOUBLE <= ecc;
      load(r, bad_sig);
      repeat (2) @(posedge REF_CLK);
      dh_count = 0;
      zf_count = 0;
      wr_count = 0;
      RST_N <= 1'b1;
      POR_N <= 1'b1;
      for (int n = 0; n < 12000 && (BRANCH_VALID | LIN_FAST_EN | FAILSAFE
           | KERNEL_BLOCKED | SOFT_RESET_REQ) !== 1'b1; n++) begin
         @(posedge REF_CLK);
      end
      repeat (6) @(posedge REF_CLK);
   endtask
   // Table of ordinary boots, then the awkward cases by hand.
   initial begin
      {RST_N, POR_N, slow, SRAM_ECC_DOUBLE, LIN_FRAME_OK, LIN_DONE} = 6'h0;
      {BOOT_MODE_STRAP_PIN, SRAM_CHK_DONE, sram_cnt} = 4'h8;
      repeat (20) @(posedge REF_CLK);
      check("idle", {SWD_EN, BRANCH_VALID, FAILSAFE}, 32'h0);
      foreach (rows[k]) begin
         boot(rows[k], 1'b0, 1'b0, 1'b0);
         check("mode", BOOT_MODE, rows[k].mode);
         check("exit", BRANCH_VALID, rows[k].mode != 2'h3);
         check("swd", SWD_EN, rows[k].swd);
         check("fast", LIN_FAST_EN, rows[k].mode == 2'h3);
         check("high writes", 32'(dh_count), 32'(rows[k].bad_sum));
         if (rows[k].mode != 2'h3) begin
            check("target", BRANCH_ADDR, rows[k].addr);
         end
         if (rows[k].bad_sum) begin
            check("high value", dh_val, sum_exp);
         end
         for (int i = 0; i < 8; i++) begin
            check("trim", cal_reg[i], cal_word(i));
         end
      end
      boot(rows[2], 1'b1, 1'b0, 1'b0);
      check("blocked", KERNEL_BLOCKED, 32'h1);
      check("no trims", 32'(wr_count), 32'h0);
      boot(rows[1], 1'b0, 1'b1, 1'b0);
      check("zero fill", 32'(zf_count), 32'h1);
      check("soft reset", SOFT_RESET_REQ, 32'h1);
      boot(rows[4], 1'b0, 1'b0, 1'b0);
      repeat (6) begin
         repeat (30) @(posedge REF_CLK);
         LIN_FRAME_OK <= 1'b1;
         LIN_DONE <= 1'b1;
         @(posedge REF_CLK);
         LIN_FRAME_OK <= 1'b0;
         LIN_DONE <= 1'b0;
      end
      check("alive", FAILSAFE, 32'h0);
      check("stays", BOOT_MODE, 32'h3);
      repeat (60) @(posedge REF_CLK);
      check("failsafe", FAILSAFE, 32'h1);
      boot(rows[2], 1'b0, 1'b0, 1'b0);
      check("kept", FAILSAFE, 32'h1);
      boot(rows[2], 1'b0, 1'b0, 1'b1);
      check("cleared", FAILSAFE, 32'h0);
      check("power up", BOOT_MODE, 32'h1);
      print_verdict();
   end
endmodule
